// file: logic/fesc_pkg.sv
/*
 Constants and types for the fiber extended status and fiber control
 register bank. Assumes one 50 MHz clock shared with the datapath.
*/
// Functional notes
// - Extended status bits 15 and 14 read 0 when the fiber mode is 00 and 1 otherwise.
// - Extended status bits 13 and 12 always read 0.
// - With block carrier extension set, received extension codes become idle in full duplex.
// - With carrier-on-transmit set, carrier sense follows own transmit, never in full duplex.
// - With force link good set, link is reported up whatever the link machine says.
// - Loopback type 0 loops through the PCS, 1 loops raw 10 bit code data.
// - The fast remote fault enable signals a remote fault in less than 2 ms.
// - The standard remote fault enable signals a remote fault after 20 ms.
// - The fiber mode field is read-only and mirrors the programmed operating mode.
// - Mode 00 is 100BASE-FX, 01 1000BASE-X, 10 SGMII system, 11 SGMII media.
package fesc_pkg;
  // clock and remote fault timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RF_FAST_MAX_US = 2_000;
  localparam int unsigned RF_STD_MIN_US = 20_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // strictly less than the fast limit
  localparam int unsigned RF_FAST_CYC = CYC_PER_US * RF_FAST_MAX_US - 1;
  localparam int unsigned RF_STD_CYC = CYC_PER_US * RF_STD_MIN_US;
  localparam int RF_CNT_W = 20;

  // register indices, byte address is four times the index
  localparam logic [7:0] EXT_STAT_IDX = 8'h0F;
  localparam logic [7:0] FCTRL_IDX = 8'h10;
  localparam logic [7:0] FSTAT_IDX = 8'h11;
  localparam logic [7:0] EXT_STAT_ADDR = 8'(EXT_STAT_IDX * 4);
  localparam logic [7:0] FCTRL_ADDR = 8'(FCTRL_IDX * 4);
  localparam logic [7:0] FSTAT_ADDR = 8'(FSTAT_IDX * 4);

  // extended status fields
  localparam int EXT_X_FD_BIT = 15;
  localparam int EXT_X_HD_BIT = 14;
  localparam int EXT_T_FD_BIT = 13;
  localparam int EXT_T_HD_BIT = 12;

  // fiber control fields
  localparam int CTL_BLK_CEXT_BIT = 13;
  localparam int CTL_CRS_TX_BIT = 11;
  localparam int CTL_FORCE_LINK_BIT = 10;
  localparam int CTL_LOOP_RAW_BIT = 8;
  localparam int CTL_RF_FAST_BIT = 5;
  localparam int CTL_RF_STD_BIT = 4;
  localparam int CTL_IRQ_POL_BIT = 2;
  localparam logic [15:0] CTL_RST = 16'h400C;
  localparam logic [15:0] CTL_WR_MASK = 16'hFFFC;

  // own status fields
  localparam int STS_LINK_BIT = 0;
  localparam int STS_RF_BIT = 1;
  localparam int STS_CRS_BIT = 2;
  localparam int STS_IRQ_BIT = 3;

  typedef enum logic [1:0] {
    FESC_MODE_FX = 2'b00,
    FESC_MODE_1000X = 2'b01,
    FESC_MODE_SGMII_SYS = 2'b10,
    FESC_MODE_SGMII_MED = 2'b11
  } fesc_mode_t;
endpackage

// file: logic/fesc_rf_timer.sv
/*
 Remote fault indication timer: delays a local fault before it is
 signalled to the link partner. Assumes same-clock fault input.
*/
`timescale 1ns/1ps
module fesc_rf_timer
  import fesc_pkg::*;
#(
  parameter int unsigned FAST_CYC = RF_FAST_CYC,
  parameter int unsigned STD_CYC = RF_STD_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_fast_en,
  input wire logic i_std_en,
  input wire logic i_fault,
  output logic o_rf_send
);
  typedef enum logic [1:0] {
    RF_IDLE = 2'b00,
    RF_WAIT = 2'b01,
    RF_SEND = 2'b10
  } fesc_rf_state_t;

  typedef struct packed {
    fesc_rf_state_t st;
    logic [RF_CNT_W-1:0] cnt;
    logic send;
  } fesc_rf_t;

  fesc_rf_t q, d;
  logic [RF_CNT_W-1:0] lim_m1;
  logic en;

  // fast enable wins if both are set against the software contract
  assign en = i_fast_en | i_std_en;
  assign lim_m1 = i_fast_en ? RF_CNT_W'(FAST_CYC - 1) : RF_CNT_W'(STD_CYC - 1);

  // fault must persist for the chosen delay before it is signalled
  always_comb begin
    d = q;
    case (q.st)
      RF_IDLE: begin
        d.cnt = '0;
        if (i_fault && en) begin
          d.st = RF_WAIT;
        end
      end
      RF_WAIT: begin
        d.cnt = q.cnt + 1'b1;
        if (!i_fault || !en) begin
          d.st = RF_IDLE;
        end else if (q.cnt == lim_m1) begin
          d.st = RF_SEND;
        end
      end
      RF_SEND: begin
        if (!i_fault || !en) begin
          d.st = RF_IDLE;
        end
      end
      default: d.st = RF_IDLE;
    endcase
    d.send = (d.st == RF_SEND);
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '{st: RF_IDLE, cnt: '0, send: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign o_rf_send = q.send;

  rf_fast_time_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(q.send) && $past(i_fast_en) |-> $past(q.cnt) == RF_CNT_W'(FAST_CYC - 1))
    else $error("fast remote fault sent at wrong time");
  rf_std_time_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(q.send) && !$past(i_fast_en) |-> $past(q.cnt) == RF_CNT_W'(STD_CYC - 1))
    else $error("standard remote fault sent at wrong time");
endmodule

// file: logic/fesc_regs.sv
/*
 Fiber extended status and fiber control register bank with an
 Avalon-MM slave and the datapath controls these registers steer.
 Assumes datapath and mode inputs come from logic on the same clock.
*/
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module fesc_regs
  import fesc_pkg::*;
#(
  parameter int unsigned FAST_CYC = RF_FAST_CYC,
  parameter int unsigned STD_CYC = RF_STD_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [1:0] i_mode_cfg,
  input wire logic i_full_duplex,
  input wire logic i_rx_cext,
  input wire logic i_tx_active,
  input wire logic i_link_sm_up,
  input wire logic i_local_fault,
  input wire logic i_irq_event,
  output logic o_rx_idle_subst,
  output logic o_crs_tx,
  output logic o_link_up,
  output logic o_loop_raw10,
  output logic o_rf_send,
  output logic o_irq_out_n
);
  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [15:0] ctrl;
    fesc_mode_t mode;
    logic idle_sub;
    logic crs;
    logic link;
    logic irq_n;
  } fesc_regs_st_t;

  fesc_regs_st_t q, d;
  logic req;
  logic [15:0] ext_word;
  logic [15:0] ctl_word;
  logic [15:0] sts_word;
  logic [15:0] rd_word;
  logic [15:0] lane_mask;
  logic rf_send;

  // a request is pending while either strobe is high
  assign req = i_avs_read | i_avs_write;

  // capability bits track the mirrored mode, twisted-pair bits stay 0
  always_comb begin
    ext_word = 16'h0000;
    ext_word[EXT_X_FD_BIT] = (q.mode != FESC_MODE_FX);
    ext_word[EXT_X_HD_BIT] = (q.mode != FESC_MODE_FX);
    ext_word[EXT_T_FD_BIT] = 1'b0;
    ext_word[EXT_T_HD_BIT] = 1'b0;
  end

  // control word read back with the read-only mode in the low bits
  assign ctl_word = {q.ctrl[15:2], q.mode};

  // live state of the block for software
  always_comb begin
    sts_word = 16'h0000;
    sts_word[STS_LINK_BIT] = q.link;
    sts_word[STS_RF_BIT] = rf_send;
    sts_word[STS_CRS_BIT] = q.crs;
    sts_word[STS_IRQ_BIT] = i_irq_event;
  end

  // read decode, unmapped addresses read as zero
  always_comb begin
    case (i_avs_address)
      EXT_STAT_ADDR: rd_word = ext_word;
      FCTRL_ADDR: rd_word = ctl_word;
      FSTAT_ADDR: rd_word = sts_word;
      default: rd_word = 16'h0000;
    endcase
  end

  // byte lanes 0 and 1 carry the 16-bit register
  assign lane_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // next state of the bank and of the steered datapath controls
  always_comb begin
    d = q;
    if (req && q.wreq) begin
      // first cycle of a request: capture read data, drop waitrequest
      d.wreq = 1'b0;
      d.rdata = {16'h0000, rd_word};
    end else begin
      // completion edge or idle: raise waitrequest again
      d.wreq = 1'b1;
      if (req && i_avs_write && i_avs_address == FCTRL_ADDR) begin
        // mode bits are not writable; reserved bits store as written
        d.ctrl = (q.ctrl & ~(lane_mask & CTL_WR_MASK)) |
                 (i_avs_writedata[15:0] & lane_mask & CTL_WR_MASK);
      end
    end
    // mode follows the programmed operating mode
    d.mode = fesc_mode_t'(i_mode_cfg);
    // extension codes become idle only in full duplex
    d.idle_sub = q.ctrl[CTL_BLK_CEXT_BIT] & i_full_duplex & i_rx_cext;
    // carrier on own transmit, half duplex only
    d.crs = q.ctrl[CTL_CRS_TX_BIT] & ~i_full_duplex & i_tx_active;
    // forced link bypasses the link machine
    d.link = q.ctrl[CTL_FORCE_LINK_BIT] | i_link_sm_up;
    // pin polarity: 1 active low, 0 active high
    d.irq_n = q.ctrl[CTL_IRQ_POL_BIT] ? ~i_irq_event : i_irq_event;
  end

  // bank register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '{wreq: 1'b1, rdata: 32'h0000_0000, ctrl: CTL_RST,
             mode: FESC_MODE_FX, idle_sub: 1'b0, crs: 1'b0,
             link: 1'b0, irq_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  // remote fault delay, fast or standard per control bits
  fesc_rf_timer #(
    .FAST_CYC(FAST_CYC),
    .STD_CYC(STD_CYC)
  ) u_rf_timer (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_fast_en(q.ctrl[CTL_RF_FAST_BIT]),
    .i_std_en(q.ctrl[CTL_RF_STD_BIT]),
    .i_fault(i_local_fault),
    .o_rf_send(rf_send)
  );

  // outputs straight from flops
  assign o_avs_waitrequest = q.wreq;
  assign o_avs_readdata = q.rdata;
  assign o_rx_idle_subst = q.idle_sub;
  assign o_crs_tx = q.crs;
  assign o_link_up = q.link;
  assign o_loop_raw10 = q.ctrl[CTL_LOOP_RAW_BIT];
  assign o_rf_send = rf_send;
  assign o_irq_out_n = q.irq_n;

  // handshake: request seen, answered one cycle later, then released
  sequence s_req_start;
    req && o_avs_waitrequest;
  endsequence

  sequence s_req_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  bus_answer_time_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_req_start |=> s_req_answer)
    else $error("waitrequest not answered in one cycle");

  sequence s_ext_read;
    i_avs_read && o_avs_waitrequest && i_avs_address == EXT_STAT_ADDR;
  endsequence

  ext_xcap_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_ext_read |=> o_avs_readdata[EXT_X_FD_BIT] == ($past(q.mode) != FESC_MODE_FX)
      && o_avs_readdata[EXT_X_HD_BIT] == ($past(q.mode) != FESC_MODE_FX))
    else $error("1000BASE-X capability does not match mode");

  ext_tcap_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_ext_read |=> o_avs_readdata[EXT_T_FD_BIT:EXT_T_HD_BIT] == 2'b00)
    else $error("1000BASE-T capability reads nonzero");

  cext_idle_sub_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    ##1 o_rx_idle_subst == ($past(q.ctrl[CTL_BLK_CEXT_BIT])
      && $past(i_full_duplex) && $past(i_rx_cext)))
    else $error("carrier extension idle substitution wrong");

  crs_on_tx_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    i_full_duplex || !q.ctrl[CTL_CRS_TX_BIT] |=> !o_crs_tx)
    else $error("carrier sense raised when not allowed");

  crs_follow_tx_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    q.ctrl[CTL_CRS_TX_BIT] && !i_full_duplex && i_tx_active |=> o_crs_tx)
    else $error("carrier sense missing on transmit");

  force_link_up_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    q.ctrl[CTL_FORCE_LINK_BIT] |=> o_link_up)
    else $error("forced link not reported up");

  link_follows_sm_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !q.ctrl[CTL_FORCE_LINK_BIT] |=> o_link_up == $past(i_link_sm_up))
    else $error("link does not follow link machine");

  sequence s_ctl_write;
    i_avs_write && !o_avs_waitrequest && i_avs_address == FCTRL_ADDR
      && i_avs_byteenable[1];
  endsequence

  loop_type_wr_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_ctl_write |=> o_loop_raw10 == $past(i_avs_writedata[CTL_LOOP_RAW_BIT]))
    else $error("loopback type not taken from write");

  irq_polarity_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    ##1 o_irq_out_n == ($past(q.ctrl[CTL_IRQ_POL_BIT]) ^ $past(i_irq_event)))
    else $error("interrupt pin polarity wrong");

  // the mode flop takes the programmed mode at every edge, so one cycle of delay
  mode_mirror_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    ##1 ctl_word[1:0] == $past(i_mode_cfg))
    else $error("mode field does not mirror programmed mode");

  mode_ro_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_ctl_write |=> ctl_word[1:0] == $past(i_mode_cfg))
    else $error("mode field changed by a write");
endmodule

// file: tb/fesc_link_partner.sv
/*
 Link partner model: feeds received extension codes and link state.
 Counts remote fault indications. Assumes the device clock and reset.
*/
`timescale 1ns/1ps
module fesc_link_partner (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_active,
  input wire logic i_rf_send,
  output logic o_rx_cext,
  output logic o_link_ok,
  output int o_rf_seen
);
  logic [7:0] lfsr_q;
  logic rf_q;

  // LFSR steps every cycle; o_rx_cext and o_link_ok take its bits only while i_active is high, and a bit can repeat
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lfsr_q <= 8'hA5;
      rf_q <= 1'h0;
      o_rx_cext <= 1'h0;
      o_link_ok <= 1'h0;
      o_rf_seen <= 0;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      o_rx_cext <= i_active & lfsr_q[0];
      o_link_ok <= i_active & lfsr_q[3];
      rf_q <= i_rf_send;
      if (i_rf_send && !rf_q) begin
        o_rf_seen <= o_rf_seen + 1;
      end
    end
  end
endmodule

// file: tb/fiber_ext_status_ctrl_regs_bench.sv
/*
 Self-checking bench for the fiber register bank, with a bench model.
 Assumes the link partner model and short remote fault timer values.
*/
`timescale 1ns/1ps
module fiber_ext_status_ctrl_regs_bench;
  import fesc_pkg::*;
  localparam int F = 10;
  localparam int S = 40;
  logic clk, nrst, rd, wr, fd, tx, lf, ev, act;
  logic wreq, idle, crs, link, loop, rf, irqn, cext, sm;
  logic [7:0] adr;
  logic [31:0] wd, q, rdata;
  logic [3:0] be;
  logic [1:0] mode;
  logic [15:0] c;
  logic [4:0] p;
  int rf_seen, err_total, checks;
  logic [31:0] seed = 32'h000072E1;

  fesc_regs #(.FAST_CYC(F), .STD_CYC(S)) i_dut (.i_ref_clk(clk), .i_nrst(nrst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_mode_cfg(mode), .i_full_duplex(fd), .i_rx_cext(cext), .i_tx_active(tx),
    .i_link_sm_up(sm), .i_local_fault(lf), .i_irq_event(ev), .o_rx_idle_subst(idle),
    .o_crs_tx(crs), .o_link_up(link), .o_loop_raw10(loop), .o_rf_send(rf),
    .o_irq_out_n(irqn));

  fesc_link_partner i_partner (.i_ref_clk(clk), .i_nrst(nrst), .i_active(act),
    .i_rf_send(rf), .o_rx_cext(cext), .o_link_ok(sm), .o_rf_seen(rf_seen));

  // clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected pins from control word and last sampled inputs
  function automatic logic [5:0] model(input logic [15:0] k, input logic [4:0] v);
    return {k[13] & v[4] & v[2], k[11] & !v[4] & v[3], k[10] | v[1], k[8], 1'h0,
      k[2] ? !v[0] : v[0]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_cyc(input int n, input int lim);
    checks++;
    if (n != lim) begin
      err_total++;
      $display("BAD %0t delay %0d expected %0d", $time, n, lim);
    end
  endtask

  // one bus cycle, held until waitrequest is sampled low
  // only the watchdog ends a wait that never gets an answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (wreq !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 16'h0000);
    chk(q, e);
  endtask

  // remote fault delay from fault to indication, then clear
  task automatic rf_time(input logic [15:0] k, input int lim);
    int n;
    bus(1'h1, FCTRL_ADDR, k);
    @(posedge clk);
    lf <= 1'h1;
    // count starts at the first edge that samples the fault
    @(posedge clk);
    n = 0;
    do begin
      @(negedge clk);
      if (rf !== 1'h1) n++;
    end while (rf !== 1'h1 && n <= lim + 5);
    chk_cyc(n, lim);
    @(posedge clk);
    lf <= 1'h0;
    repeat (2) @(negedge clk);
    chk(32'(rf), 32'h0);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("BAD %0t watchdog", $time);
    end_of_test();
  end

  // main sequence
  initial begin
    {nrst, rd, wr, fd, tx, lf, ev, act} = 8'h00;
    adr = 8'h00;
    wd = 32'h0;
    be = 4'h3;
    mode = 2'h0;
    err_total = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    chk(32'({wreq, irqn, link, rf}), 32'hC);
    nrst <= 1'h1;
    rd_chk(FCTRL_ADDR, 32'h400C);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      mode <= 2'(m);
      repeat (2) @(posedge clk);
      rd_chk(EXT_STAT_ADDR, (m == 0) ? 32'h0 : 32'hC000);
      rd_chk(FCTRL_ADDR, 32'h400C | 32'(m));
    end
    bus(1'h1, 8'h00, 16'hFFFF);
    rd_chk(8'h00, 32'h0);
    bus(1'h1, EXT_STAT_ADDR, 16'h3FFF);
    rd_chk(EXT_STAT_ADDR, 32'hC000);
    // lane 0 only: the upper control byte must keep its value
    be <= 4'h1;
    bus(1'h1, FCTRL_ADDR, 16'h002C);
    be <= 4'h3;
    rd_chk(FCTRL_ADDR, 32'h402F);
    act <= 1'h1;
    repeat (12) begin
      c = (16'(xs()) & 16'h2D34) | 16'h400B;
      if (c[5]) c[4] = 1'h0;
      bus(1'h1, FCTRL_ADDR, c);
      rd_chk(FCTRL_ADDR, {16'h0000, (c & CTL_WR_MASK) | 16'h0003});
      @(negedge clk);
      p = {fd, tx, cext, sm, ev};
      repeat (24) begin
        @(posedge clk);
        {fd, tx, ev} <= 3'(xs());
        @(negedge clk);
        chk(32'({idle, crs, link, loop, rf, irqn}), 32'(model(c, p)));
        p = {fd, tx, cext, sm, ev};
      end
    end
    rf_time(16'h4028, F);
    rf_time(16'h4018, S);
    chk(32'(rf_seen), 32'h2);
    end_of_test();
  end
endmodule
